// ==== hdl/power_state_control.sv ====
// top: power state machine driven by sleep, power keep and boot select
// assumes: pins asynchronous; config bits static from boot load
`timescale 1ns/1ns
`default_nettype none
module power_state_control
  import power_state_pkg::*;
(
  input  wire logic                                    CLK_SYS,
  input  wire logic                                    RST,
  input  wire logic                                    SLEEP_PIN,
  input  wire logic                                    POWER_KEEP_INPUT,
  input  wire logic                                    BOOT_SELECT_INPUT,
  input  wire logic                                    BOOT_LOAD,
  input  wire logic                                    AUTO_KEEP_MODE,
  input  wire logic                                    LONGPRESS_CFG,
  input  wire logic                                    SLEEP_POL_INV,
  input  wire logic                                    SLEEP_DISABLE,
  input  wire logic                                    POWER_ON_DISABLE,
  input  wire logic                                    KEEP_IRQ_MASK,
  input  wire logic                                    DEVICE_ON_SET,
  input  wire logic                                    DEVICE_ON_CLR,
  input  wire logic                                    BUTTON_LONGPRESS,
  input  wire logic [power_state_pkg::LINEAR_COUNT-1:0]   SLEEP_KEEP_LINEAR_MASK,
  input  wire logic [power_state_pkg::RESOURCE_COUNT-1:0] SLEEP_KEEP_RESOURCE_MASK,
  input  wire logic [power_state_pkg::SEQ_OUT_COUNT-1:0]  SEQ_OUT_ACTIVE,
  input  wire logic [power_state_pkg::SEQ_OUT_COUNT-1:0]  SEQ_OUT_SLEEP,
  output logic [2:0]                                   POWER_STATE,
  output logic [power_state_pkg::LINEAR_COUNT-1:0]        LINEAR_FULL_LOAD,
  output logic [power_state_pkg::RESOURCE_COUNT-1:0]      RESOURCE_FULL_LOAD,
  output logic                                         SLOW_CLOCK_RUN,
  output logic                                         SLOW_CLOCK_SOURCE,
  output logic                                         SEQUENCED_OUTPUT_A,
  output logic                                         SEQUENCED_OUTPUT_B,
  output logic                                         SEQUENCED_OUTPUT_C,
  output logic                                         SEQUENCED_OUTPUT_D,
  output logic                                         SYSTEM_RESET_OUT,
  output logic                                         CORE_RESET,
  output logic                                         DEVICE_ON_BIT,
  output logic                                         LONGPRESS_ENABLE,
  output logic [power_state_pkg::SEQ_SEL_WIDTH-1:0]       SEQUENCE_SELECT,
  output logic                                         KEEP_RISE_EVENT,
  output logic                                         KEEP_FALL_EVENT,
  output logic                                         KEEP_IRQ
);

  import power_state_pkg::*;

  power_state_type                state_ff;
  power_state_type                nxt_state;
  logic [LINEAR_COUNT-1:0]        linear_ff;
  logic [RESOURCE_COUNT-1:0]      resource_ff;
  logic [SEQ_OUT_COUNT-1:0]       seq_ff;
  logic                           sys_reset_ff;
  logic                           device_on_ff;
  logic                           longpress_ff;
  logic                           mode_ff;
  logic [SEQ_SEL_WIDTH-1:0]       seq_sel_ff;
  logic                           rise_ff;
  logic                           fall_ff;
  logic                           irq_ff;
  logic                           sleep_lvl;
  logic                           sleep_rise;
  logic                           sleep_fall;
  logic                           keep_lvl;
  logic                           keep_rise;
  logic                           keep_fall;
  logic                           boot_lvl;
  logic                           sleep_enter;
  logic                           sleep_exit;
  logic                           keep_on;
  logic                           reset_rise;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  input_sync u_sleep_sync
  (
    .clk   (CLK_SYS),
    .rst   (RST),
    .pin   (SLEEP_PIN),
    .level (sleep_lvl),
    .rise  (sleep_rise),
    .fall  (sleep_fall)
  );

  input_sync u_keep_sync
  (
    .clk   (CLK_SYS),
    .rst   (RST),
    .pin   (POWER_KEEP_INPUT),
    .level (keep_lvl),
    .rise  (keep_rise),
    .fall  (keep_fall)
  );

  input_sync u_boot_sync
  (
    .clk   (CLK_SYS),
    .rst   (RST),
    .pin   (BOOT_SELECT_INPUT),
    .level (boot_lvl),
    .rise  (),
    .fall  ()
  );

  // ----------------------------------------------------------------
  // sleep edges, no debounce filter
  // ----------------------------------------------------------------
  assign sleep_enter = SLEEP_POL_INV ? sleep_rise : sleep_fall;
  assign sleep_exit  = SLEEP_POL_INV ? sleep_fall : sleep_rise;

  // power keep pin in power keep mode, or device on bit, holds the device on
  assign keep_on = ((mode_ff == MODE_POWER_KEEP) & keep_lvl)
                   | device_on_ff;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF:
        if (keep_on & ~POWER_ON_DISABLE)
          nxt_state = ST_ACTIVE;
      ST_ACTIVE:
        if (~keep_on)
          nxt_state = ST_OFF;
        else if (sleep_enter & ~SLEEP_DISABLE)
          nxt_state = ST_SLEEP;
      ST_SLEEP:
        if (~keep_on)
          nxt_state = ST_OFF;
        else if (sleep_exit)
          nxt_state = ST_ACTIVE;
      default:
        nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      state_ff <= ST_OFF;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------
  // resources in sleep
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      linear_ff   <= LINEAR_MASK_RST;
      resource_ff <= RESOURCE_MASK_RST;
      seq_ff      <= '0;
    end
    else
    begin
      unique case (nxt_state)
        ST_ACTIVE:
        begin
          linear_ff   <= '1;
          resource_ff <= '1;
          seq_ff      <= SEQ_OUT_ACTIVE;
        end
        ST_SLEEP:
        begin
          linear_ff   <= SLEEP_KEEP_LINEAR_MASK;
          resource_ff <= SLEEP_KEEP_RESOURCE_MASK;
          seq_ff      <= SEQ_OUT_SLEEP;
        end
        default:
        begin
          linear_ff   <= '0;
          resource_ff <= '0;
          seq_ff      <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // processor reset and device on bit
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      sys_reset_ff <= 1'b0;
    else
      sys_reset_ff <= (state_ff != ST_OFF);
  end

  assign reset_rise = (state_ff != ST_OFF) & ~sys_reset_ff;

  // set beats clear so a rising reset is never lost
  always_ff @(posedge CLK_SYS)
  begin
    if (RST | BOOT_LOAD)
      device_on_ff <= 1'b0;
    else if (DEVICE_ON_SET | ((mode_ff == MODE_GPI) & reset_rise))
      device_on_ff <= 1'b1;
    else if (DEVICE_ON_CLR)
      device_on_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // boot configuration capture
  // ----------------------------------------------------------------
  // captured after release so straps never feed the reset path
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      mode_ff      <= MODE_POWER_KEEP;
      longpress_ff <= 1'b0;
      seq_sel_ff   <= SEQ_PRIMARY;
    end
    else if (BOOT_LOAD)
    begin
      mode_ff      <= AUTO_KEEP_MODE;
      longpress_ff <= LONGPRESS_CFG;
      seq_sel_ff   <= boot_lvl ? SEQ_ALTERNATE : SEQ_PRIMARY;
    end
  end

  // ----------------------------------------------------------------
  // power keep pin edge events
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      rise_ff <= keep_rise;
      fall_ff <= keep_fall;
      irq_ff  <= (keep_rise | keep_fall) & ~KEEP_IRQ_MASK;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign POWER_STATE        = state_ff;
  assign LINEAR_FULL_LOAD   = linear_ff;
  assign RESOURCE_FULL_LOAD = resource_ff;
  assign SLOW_CLOCK_RUN     = resource_ff[SLOW_CLOCK_BIT];
  assign SLOW_CLOCK_SOURCE  = SOURCE_CRYSTAL;
  assign SEQUENCED_OUTPUT_A = seq_ff[0];
  assign SEQUENCED_OUTPUT_B = seq_ff[1];
  assign SEQUENCED_OUTPUT_C = seq_ff[2];
  assign SEQUENCED_OUTPUT_D = seq_ff[3];
  assign SYSTEM_RESET_OUT   = sys_reset_ff;
  assign CORE_RESET         = (state_ff == ST_OFF);
  assign DEVICE_ON_BIT      = device_on_ff;
  assign LONGPRESS_ENABLE   = longpress_ff & BUTTON_LONGPRESS;
  assign SEQUENCE_SELECT    = seq_sel_ff;
  assign KEEP_RISE_EVENT    = rise_ff;
  assign KEEP_FALL_EVENT    = fall_ff;
  assign KEEP_IRQ           = irq_ff;

endmodule : power_state_control
`default_nettype wire

// ==== hdl/power_state_pkg.sv ====
// package: constants, states and widths for the power state control block
// assumes: one clock domain, synchronous active-high reset
// How it works
// - active sleep edge enters sleep from active
// - opposite sleep edge returns to active
// - sleep input edge based, no debounce
// - sleep puts unkept resources in low power
// - keep-on mask bit one keeps full load
// - slow clock runs in sleep if masked
// - sequenced outputs follow the sleep state
// - mode bit picks power keep or gpi
// - power keep high on, low off
// - power keep edges raise maskable interrupt
// - gpi edges raise maskable interrupt
// - gpi mode: reset out rise sets device on
// - boot select picks power-up sequence
// - boot select sampled without debounce
// - device on bit cleared after boot load
// - boot config enables long-press turnoff
// - digital core held in reset when off
// - slow clock source defaults to crystal
// - reset out low until active reached
package power_state_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int LINEAR_COUNT   = 8;
  localparam int RESOURCE_COUNT = 8;
  localparam int SEQ_OUT_COUNT  = 4;
  localparam int SEQ_SEL_WIDTH  = 2;

  // ----------------------------------------------------------------
  // reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [LINEAR_COUNT-1:0]   LINEAR_MASK_RST   = 8'h00;
  localparam logic [RESOURCE_COUNT-1:0] RESOURCE_MASK_RST = 8'h00;
  localparam int                        SLOW_CLOCK_BIT    = 7;
  localparam logic                      SOURCE_CRYSTAL    = 1'b0;
  localparam logic                      MODE_POWER_KEEP   = 1'b0;
  localparam logic                      MODE_GPI          = 1'b1;
  localparam logic [SEQ_SEL_WIDTH-1:0]  SEQ_PRIMARY       = 2'h0;
  localparam logic [SEQ_SEL_WIDTH-1:0]  SEQ_ALTERNATE     = 2'h1;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_OFF    = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SLEEP  = 3'h4
  } power_state_type;

endpackage : power_state_pkg

// ==== hdl/input_sync.sv ====
// two-stage synchroniser with edge detection for one pin
// assumes: pin is asynchronous to CLK_SYS
`timescale 1ns/1ns
`default_nettype none
module input_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // ----------------------------------------------------------------
  // crossing: meta_ff feeds sync_ff only
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;

endmodule : input_sync
`default_nettype wire

// ==== dv/host_model.sv ====
// partner: host processor driving sleep, power keep and boot select pins
// assumes: testbench calls the tasks; pins move after falling edges
`timescale 1ns/1ns
`default_nettype none
module host_model
(
  input  wire logic clk,
  output var logic  sleep_pin,
  output var logic  keep_pin,
  output var logic  boot_pin
);
  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  initial
  begin
    sleep_pin = 1'b1;
    keep_pin  = 1'b0;
    boot_pin  = 1'b0;
  end

  // clean levels only; bounce is not modelled
  task automatic drive_sleep(input logic v);
    @(negedge clk);
    sleep_pin = v;
  endtask : drive_sleep

  task automatic drive_keep(input logic v);
    @(negedge clk);
    keep_pin = v;
  endtask : drive_keep

  // only moved while off, long before a boot load
  task automatic drive_boot(input logic v);
    @(negedge clk);
    boot_pin = v;
  endtask : drive_boot
endmodule : host_model
`default_nettype wire

// ==== dv/power_state_monitor.sv ====
// checker: port-level timing of the power state control block
// assumes: bound to power_state_control; config static between loads
`timescale 1ns/1ns
`default_nettype none
module power_state_monitor
  import power_state_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       SLEEP_PIN,
  input wire logic       POWER_KEEP_INPUT,
  input wire logic       AUTO_KEEP_MODE,
  input wire logic       SLEEP_POL_INV,
  input wire logic       SLEEP_DISABLE,
  input wire logic       POWER_ON_DISABLE,
  input wire logic       BOOT_LOAD,
  input wire logic [7:0] SLEEP_KEEP_LINEAR_MASK,
  input wire logic [7:0] SLEEP_KEEP_RESOURCE_MASK,
  input wire logic [2:0] POWER_STATE,
  input wire logic [7:0] LINEAR_FULL_LOAD,
  input wire logic [7:0] RESOURCE_FULL_LOAD,
  input wire logic       SYSTEM_RESET_OUT,
  input wire logic       CORE_RESET,
  input wire logic       DEVICE_ON_BIT
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  core_held_off_a: assert property (
    CORE_RESET == (POWER_STATE == ST_OFF))
    else $error("core reset not tied to off state");
  reset_out_late_a: assert property (
    $rose(SYSTEM_RESET_OUT) |-> $past(POWER_STATE) == ST_ACTIVE)
    else $error("reset out rose before active");
  reset_held_off_a: assert property (
    POWER_STATE == ST_OFF |=> !SYSTEM_RESET_OUT)
    else $error("reset out high after off");
  sleep_keep_a: assert property (
    POWER_STATE == ST_SLEEP |->
    LINEAR_FULL_LOAD == SLEEP_KEEP_LINEAR_MASK &&
    RESOURCE_FULL_LOAD == SLEEP_KEEP_RESOURCE_MASK)
    else $error("sleep loads differ from keep masks");
  sleep_entry_a: assert property (
    POWER_STATE == ST_ACTIVE && !SLEEP_DISABLE && $changed(SLEEP_PIN)
    && SLEEP_PIN == SLEEP_POL_INV |-> ##[2:5] POWER_STATE == ST_SLEEP)
    else $error("active edge did not enter sleep");
  sleep_exit_a: assert property (
    POWER_STATE == ST_SLEEP && $changed(SLEEP_PIN)
    && SLEEP_PIN != SLEEP_POL_INV |-> ##[2:5] POWER_STATE == ST_ACTIVE)
    else $error("opposite edge did not leave sleep");
  sleep_refused_a: assert property (
    POWER_STATE == ST_ACTIVE && SLEEP_DISABLE |=> POWER_STATE != ST_SLEEP)
    else $error("sleep entered while disabled");
  keep_on_a: assert property (
    POWER_STATE == ST_OFF && !AUTO_KEEP_MODE && !POWER_ON_DISABLE
    && $rose(POWER_KEEP_INPUT) |-> ##[2:5] POWER_STATE == ST_ACTIVE)
    else $error("keep high did not power on");
  power_on_block_a: assert property (
    POWER_STATE == ST_OFF && POWER_ON_DISABLE |=> POWER_STATE == ST_OFF)
    else $error("left off while power on disabled");
  keep_off_a: assert property (
    POWER_STATE != ST_OFF && !AUTO_KEEP_MODE && !DEVICE_ON_BIT
    && $fell(POWER_KEEP_INPUT) |-> ##[2:5] POWER_STATE == ST_OFF)
    else $error("keep low did not power off");
  auto_keep_a: assert property (
    AUTO_KEEP_MODE && $rose(SYSTEM_RESET_OUT) |-> ##[0:1] DEVICE_ON_BIT)
    else $error("device on not set automatically");
  boot_clear_a: assert property (
    BOOT_LOAD |=> !DEVICE_ON_BIT)
    else $error("device on not cleared by boot load");
endmodule : power_state_monitor

bind power_state_control power_state_monitor mon (.*);
`default_nettype wire

// ==== dv/testbench.sv ====
// testbench: directed power state sequences against a host model
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import power_state_pkg::*;
  logic CLK_SYS, RST, SLEEP_PIN, POWER_KEEP_INPUT, BOOT_SELECT_INPUT;
  logic BOOT_LOAD, AUTO_KEEP_MODE, LONGPRESS_CFG, SLEEP_POL_INV;
  logic SLEEP_DISABLE, POWER_ON_DISABLE, KEEP_IRQ_MASK, DEVICE_ON_SET;
  logic DEVICE_ON_CLR, BUTTON_LONGPRESS, SLOW_CLOCK_RUN, SLOW_CLOCK_SOURCE;
  logic SEQUENCED_OUTPUT_A, SEQUENCED_OUTPUT_B, SEQUENCED_OUTPUT_C;
  logic SEQUENCED_OUTPUT_D, SYSTEM_RESET_OUT, CORE_RESET, DEVICE_ON_BIT;
  logic LONGPRESS_ENABLE, KEEP_RISE_EVENT, KEEP_FALL_EVENT, KEEP_IRQ;
  logic [7:0] SLEEP_KEEP_LINEAR_MASK, SLEEP_KEEP_RESOURCE_MASK;
  logic [7:0] LINEAR_FULL_LOAD, RESOURCE_FULL_LOAD;
  logic [3:0] SEQ_OUT_ACTIVE, SEQ_OUT_SLEEP, seq_out;
  logic [2:0] POWER_STATE;
  logic [1:0] SEQUENCE_SELECT;
  int n_fail = 0, num_checks = 0, n_rise = 0, n_fall = 0, n_irq = 0;

  power_state_control uut (.*);
  host_model host (.clk(CLK_SYS), .sleep_pin(SLEEP_PIN),
    .keep_pin(POWER_KEEP_INPUT), .boot_pin(BOOT_SELECT_INPUT));
  assign seq_out = {SEQUENCED_OUTPUT_D, SEQUENCED_OUTPUT_C,
    SEQUENCED_OUTPUT_B, SEQUENCED_OUTPUT_A};

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  // one-cycle pulses are counted, not caught by waiting
  always @(posedge CLK_SYS)
  begin
    if (KEEP_RISE_EVENT === 1'b1) n_rise++;
    if (KEEP_FALL_EVENT === 1'b1) n_fall++;
    if (KEEP_IRQ === 1'b1) n_irq++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask : tick

  task automatic boot(input logic mode, input logic cfg);
    AUTO_KEEP_MODE = mode;
    LONGPRESS_CFG = cfg;
    BOOT_LOAD = 1'b1;
    tick(1);
    BOOT_LOAD = 1'b0;
    tick(1);
  endtask : boot

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #4000;
    n_fail++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    RST = 1'b1;
    {BOOT_LOAD, AUTO_KEEP_MODE, LONGPRESS_CFG, SLEEP_POL_INV, SLEEP_DISABLE,
      POWER_ON_DISABLE, KEEP_IRQ_MASK, DEVICE_ON_SET, DEVICE_ON_CLR} = '0;
    BUTTON_LONGPRESS = 1'b1;
    {SLEEP_KEEP_LINEAR_MASK, SLEEP_KEEP_RESOURCE_MASK} = '0;
    SEQ_OUT_ACTIVE = 4'h9;
    SEQ_OUT_SLEEP = 4'h6;
    tick(3);
    RST = 1'b0;
    chk(CORE_RESET, 1'b1);
    chk(SLOW_CLOCK_SOURCE, SOURCE_CRYSTAL);
    host.drive_boot(1'b1);
    tick(3);
    boot(MODE_POWER_KEEP, 1'b1);
    chk(SEQUENCE_SELECT, SEQ_ALTERNATE);
    chk(LONGPRESS_ENABLE, 1'b1);
    BUTTON_LONGPRESS = 1'b0;
    host.drive_keep(1'b1);
    tick(6);
    chk(LONGPRESS_ENABLE, 1'b0);
    chk(POWER_STATE, ST_ACTIVE);
    chk(SYSTEM_RESET_OUT, 1'b1);
    chk(LINEAR_FULL_LOAD, 8'hFF);
    chk(DEVICE_ON_BIT, 1'b0);
    chk(seq_out, SEQ_OUT_ACTIVE);
    chk(8'(n_irq), 8'h01);
    for (int p = 0; p < 2; p++)
    begin
      // polarity only moves while sleep entry is refused
      SLEEP_DISABLE = 1'b1;
      SLEEP_POL_INV = p[0];
      SLEEP_KEEP_LINEAR_MASK = p[0] ? 8'h5A : 8'hA5;
      SLEEP_KEEP_RESOURCE_MASK = p[0] ? 8'h3C : 8'h81;
      SEQ_OUT_ACTIVE = p[0] ? 4'h3 : 4'h9;
      SEQ_OUT_SLEEP = p[0] ? 4'hC : 4'h6;
      // park the pin at idle so the next move is a real entry edge
      host.drive_sleep(!p[0]);
      tick(6);
      host.drive_sleep(p[0]);
      tick(6);
      chk(POWER_STATE, ST_ACTIVE);
      host.drive_sleep(!p[0]);
      tick(6);
      SLEEP_DISABLE = 1'b0;
      host.drive_sleep(p[0]);
      tick(6);
      chk(POWER_STATE, ST_SLEEP);
      chk(LINEAR_FULL_LOAD, SLEEP_KEEP_LINEAR_MASK);
      chk(RESOURCE_FULL_LOAD, SLEEP_KEEP_RESOURCE_MASK);
      chk(SLOW_CLOCK_RUN, !p[0]);
      chk(seq_out, SEQ_OUT_SLEEP);
      host.drive_sleep(!p[0]);
      tick(6);
      chk(POWER_STATE, ST_ACTIVE);
      chk(seq_out, SEQ_OUT_ACTIVE);
    end
    KEEP_IRQ_MASK = 1'b1;
    BUTTON_LONGPRESS = 1'b1;
    host.drive_keep(1'b0);
    tick(6);
    chk(POWER_STATE, ST_OFF);
    POWER_ON_DISABLE = 1'b1;
    host.drive_keep(1'b1);
    tick(6);
    chk(POWER_STATE, ST_OFF);
    POWER_ON_DISABLE = 1'b0;
    tick(6);
    chk(POWER_STATE, ST_ACTIVE);
    host.drive_keep(1'b0);
    tick(6);
    // boot select only moves once the device is off
    host.drive_boot(1'b0);
    tick(3);
    chk(8'(n_fall), 8'h02);
    chk(8'(n_rise), 8'h02);
    chk(8'(n_irq), 8'h01);
    boot(MODE_GPI, 1'b0);
    chk(SEQUENCE_SELECT, SEQ_PRIMARY);
    chk(LONGPRESS_ENABLE, 1'b0);
    KEEP_IRQ_MASK = 1'b0;
    host.drive_keep(1'b1);
    tick(6);
    chk(POWER_STATE, ST_OFF);
    chk(8'(n_irq), 8'h02);
    chk(8'(n_rise), 8'h03);
    // set wins over clear; the later clear is undone by the reset rise
    {DEVICE_ON_SET, DEVICE_ON_CLR} = 2'h3;
    tick(1);
    {DEVICE_ON_SET, DEVICE_ON_CLR} = 2'h1;
    tick(1);
    {DEVICE_ON_SET, DEVICE_ON_CLR} = 2'h0;
    tick(6);
    chk(POWER_STATE, ST_ACTIVE);
    chk(DEVICE_ON_BIT, 1'b1);
    boot(MODE_GPI, 1'b0);
    chk(DEVICE_ON_BIT, 1'b0);
    tick(6);
    chk(CORE_RESET, 1'b1);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
